// ==== rtl/cdac_pkg.sv ====
// constants for the character display attribute controller
// assumes a 200 MHz core clock and an 8-bit host strobe bus
`default_nettype none
package cdac_pkg;
    // ------------------------------------------------------------
    // control word and digit character fields
    // ------------------------------------------------------------
    localparam int BRIGHT_LSB = 0;
    localparam int ATTR_LSB = 2;
    localparam int CURSOR_EN_BIT = 4;
    localparam int DISP_BLINK_BIT = 5;
    localparam int LAMP_TEST_BIT = 6;
    localparam int CLEAR_BIT = 7;
    localparam int FLAG_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIGIT_RESET = 8'h00;
    // codes below this value show a dark digit
    localparam logic [6:0] FIRST_GLYPH = 7'h20;
    // brightness codes
    localparam logic [1:0] BRIGHT_BLANK = 2'h0;
    localparam logic [1:0] BRIGHT_QUARTER = 2'h1;
    localparam logic [1:0] BRIGHT_HALF = 2'h2;
    localparam logic [1:0] BRIGHT_FULL = 2'h3;
    // attribute selector codes (bits 3:2)
    localparam logic [1:0] ATTR_CURSOR = 2'h0;
    localparam logic [1:0] ATTR_BLINK = 2'h1;
    localparam logic [1:0] ATTR_BLINK_CURSOR = 2'h2;
    localparam logic [1:0] ATTR_ALTERNATE = 2'h3;
    // ------------------------------------------------------------
    // timing: blink half period 250 ms gives about 2 Hz
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
endpackage
`default_nettype wire

// ==== rtl/cdac_display_ctrl.sv ====
// character and control word store of a four digit dot matrix display
// assumes host strobes are asynchronous pins, synchronised here
// Contract
// R01: host holds register select high when writing digit characters
// R02: digit with flag bit set gets selected highlight, others normal
// R03: codes 0x00 to 0x1F show a fully dark digit
// R04: control 0x17 gives full brightness with flagged digits blinking
// R05: code 0xD3 in leftmost digit is flagged S taking the highlight
// R06: control 0x1F alternates flagged digits between glyph and cursor
// R07: control 0x23 blinks whole display regardless of flags
// R08: select low reaches one control word at 0..3; 4..7 are digits
// R09: bits 1:0 brightness, bit 4 cursor enable, bits 3:2 attribute
// R10: bit 5 blinks display near 2 Hz; bit 6 lamp test half
// R11: control write with bit 7 set clears all digits and control
// R12: low seven bits pick the glyph; attributes never alter stored code
`timescale 1ns/10ps
`default_nettype none
module cdac_display_ctrl #(
    parameter int BLINK_HALF = cdac_pkg::BLINK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [1:0] addr_low,
    input wire logic register_space_select,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic [6:0] glyph_code_0,
    output logic [6:0] glyph_code_1,
    output logic [6:0] glyph_code_2,
    output logic [6:0] glyph_code_3,
    output logic [3:0] digit_dark,
    output logic [3:0] digit_cursor,
    output logic [3:0] digit_half,
    output logic [1:0] brightness,
    output logic [7:0] control_word
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = 15;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    assign pin_raw = {chip_select_low_n, chip_select_high, wr_n, rd_n,
                      addr_low, register_space_select, data_in};

    // two stage sync; first stage read only by second
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic sel;
    logic wr_lvl;
    logic rd_lvl;
    logic [2:0] addr;
    logic [7:0] din;
    assign sel = !sync2_r[14] && sync2_r[13];
    assign wr_lvl = sel && !sync2_r[12];
    assign rd_lvl = sel && !sync2_r[11];
    assign addr = {sync2_r[8], sync2_r[10:9]};
    assign din = sync2_r[7:0];

    // ------------------------------------------------------------
    // write edge detect, register store
    // ------------------------------------------------------------
    logic wr_d_r;
    logic wr_d_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] digit_r [4];
    logic [7:0] digit_nxt [4];
    logic wr_pulse;
    // act once per strobe, on its falling edge, after data has settled
    assign wr_pulse = wr_lvl && !wr_d_r;

    always_comb begin
        wr_d_nxt = wr_lvl;
        ctrl_nxt = ctrl_r;
        for (int i = 0; i < 4; i++) digit_nxt[i] = digit_r[i];
        if (wr_pulse) begin
            if (!addr[2]) begin
                // one shared word behind all four low addresses
                if (din[cdac_pkg::CLEAR_BIT]) begin // R11
                    ctrl_nxt = cdac_pkg::CTRL_RESET;
                    for (int i = 0; i < 4; i++)
                        digit_nxt[i] = cdac_pkg::DIGIT_RESET;
                end else begin
                    ctrl_nxt = din; // R08 R04 R06 R07
                end
            end else begin
                digit_nxt[addr[1:0]] = din; // R08 R01 R05 R12
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_d_r <= 1'b0;
            ctrl_r <= cdac_pkg::CTRL_RESET;
            for (int i = 0; i < 4; i++) digit_r[i] <= cdac_pkg::DIGIT_RESET;
        end else begin
            wr_d_r <= wr_d_nxt;
            ctrl_r <= ctrl_nxt;
            for (int i = 0; i < 4; i++) digit_r[i] <= digit_nxt[i];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] dout_r;
    logic [7:0] dout_nxt;
    logic oe_r;
    logic oe_nxt;
    // any low address returns the control word
    always_comb begin
        oe_nxt = rd_lvl;
        dout_nxt = addr[2] ? digit_r[addr[1:0]] : ctrl_r; // R08
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dout_r <= 8'h00;
            oe_r <= 1'b0;
        end else begin
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
        end
    end
    assign data_out = dout_r;
    assign data_oe = oe_r;

    // ------------------------------------------------------------
    // blink timebase
    // ------------------------------------------------------------
    logic [31:0] blink_cnt_r;
    logic [31:0] blink_cnt_nxt;
    logic blink_ph_r;
    logic blink_ph_nxt;
    // free running so multiple blink users stay in phase
    always_comb begin
        blink_ph_nxt = blink_ph_r;
        if (blink_cnt_r >= 32'(BLINK_HALF - 1)) begin
            blink_cnt_nxt = 32'h0;
            blink_ph_nxt = !blink_ph_r; // R10
        end else begin
            blink_cnt_nxt = blink_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            blink_cnt_r <= 32'h0;
            blink_ph_r <= 1'b0;
        end else begin
            blink_cnt_r <= blink_cnt_nxt;
            blink_ph_r <= blink_ph_nxt;
        end
    end

    // ------------------------------------------------------------
    // per digit presentation
    // ------------------------------------------------------------
    logic [6:0] glyph_r [4];
    logic [6:0] glyph_nxt [4];
    logic [3:0] dark_r;
    logic [3:0] dark_nxt;
    logic [3:0] cur_r;
    logic [3:0] cur_nxt;
    logic [3:0] half_r;
    logic [3:0] half_nxt;
    logic [1:0] attr;
    logic cur_en;
    logic lamp;
    logic dblink;
    assign attr = ctrl_r[cdac_pkg::ATTR_LSB +: 2];
    assign cur_en = ctrl_r[cdac_pkg::CURSOR_EN_BIT];
    assign lamp = ctrl_r[cdac_pkg::LAMP_TEST_BIT];
    assign dblink = ctrl_r[cdac_pkg::DISP_BLINK_BIT];

    // lamp test overrides all; whole blink then flags; store untouched
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            glyph_nxt[i] = digit_r[i][6:0]; // R12
            // first 32 codes never show a glyph
            dark_nxt[i] = digit_r[i][6:0] < cdac_pkg::FIRST_GLYPH; // R03
            cur_nxt[i] = 1'b0;
            half_nxt[i] = 1'b0;
            if (cur_en && digit_r[i][cdac_pkg::FLAG_BIT]) begin // R02 R05
                case (attr) // R09
                    cdac_pkg::ATTR_CURSOR: cur_nxt[i] = 1'b1;
                    cdac_pkg::ATTR_BLINK: begin
                        if (blink_ph_r) dark_nxt[i] = 1'b1; // R04
                    end
                    cdac_pkg::ATTR_BLINK_CURSOR: begin
                        cur_nxt[i] = !blink_ph_r;
                        if (blink_ph_r) dark_nxt[i] = 1'b1;
                    end
                    default: cur_nxt[i] = blink_ph_r; // R06
                endcase
            end
            if (cur_nxt[i]) begin
                dark_nxt[i] = 1'b0;
                half_nxt[i] = 1'b1;
            end
            if (dblink && blink_ph_r) begin // R07 R10
                dark_nxt[i] = 1'b1;
                cur_nxt[i] = 1'b0;
            end
            if (lamp) begin // R10
                dark_nxt[i] = 1'b0;
                cur_nxt[i] = 1'b1;
                half_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) glyph_r[i] <= 7'h00;
            dark_r <= 4'hF;
            cur_r <= 4'h0;
            half_r <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) glyph_r[i] <= glyph_nxt[i];
            dark_r <= dark_nxt;
            cur_r <= cur_nxt;
            half_r <= half_nxt;
        end
    end

    assign glyph_code_0 = glyph_r[0];
    assign glyph_code_1 = glyph_r[1];
    assign glyph_code_2 = glyph_r[2];
    assign glyph_code_3 = glyph_r[3];
    assign digit_dark = dark_r;
    assign digit_cursor = cur_r;
    assign digit_half = half_r;
    assign brightness = ctrl_r[cdac_pkg::BRIGHT_LSB +: 2]; // R09
    assign control_word = ctrl_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    clear_all_a: assert property (wr_pulse && !addr[2] && din[7] // R11
        |=> ctrl_r == 8'h00 && digit_r[3] == 8'h00)
        else $error("clear did not erase store");
    ctrl_write_a: assert property (wr_pulse && !addr[2] && !din[7] // R08
        |=> ctrl_r == $past(din))
        else $error("control word not stored");
    digit_write_a: assert property (wr_pulse && addr == 3'h7 // R05
        |=> digit_r[3] == $past(din))
        else $error("leftmost digit not stored");
    dark_code_a: assert property (!lamp && !dblink && !cur_en // R03
        && digit_r[0][6:5] == 2'h0 |=> digit_dark[0])
        else $error("control code not dark");
    plain_digit_a: assert property (!lamp && !dblink // R02
        && !digit_r[2][7] && digit_r[2][6:5] != 2'h0
        |=> !digit_dark[2] && !digit_cursor[2])
        else $error("unflagged digit altered");
    lamp_test_a: assert property (lamp |=> digit_half == 4'hF) // R10
        else $error("lamp test not lit");
    disp_blink_a: assert property (dblink && blink_ph_r && !lamp // R07
        |=> digit_dark == 4'hF)
        else $error("display blink off phase not dark");
    glyph_keep_a: assert property (##1 glyph_code_2 // R12
        == $past(digit_r[2][6:0]))
        else $error("glyph code altered");
    bright_level_a: assert property (wr_pulse && !addr[2] && !din[7] // R09
        |=> brightness == $past(din[1:0]))
        else $error("brightness mismatch");
    cursor_show_a: assert property (cur_en && attr == 2'h0 // R09
        && digit_r[1][7] && !lamp && !dblink |=> digit_cursor[1])
        else $error("cursor missing");
    ctrl_read_a: assert property (rd_lvl && !addr[2] // R08
        |=> data_out == $past(ctrl_r) && data_oe)
        else $error("control read wrong");

    blink_attr_c: cover property (ctrl_r == 8'h17 && digit_r[1][7]); // R04
    alt_c: cover property (ctrl_r == 8'h1F && digit_cursor[3]); // R06
    whole_c: cover property (ctrl_r == 8'h23 && digit_dark == 4'hF);
    clear_c: cover property (wr_pulse && !addr[2] && din[7]);
endmodule // cdac_display_ctrl
`default_nettype wire

// ==== tb/cdac_host_model.sv ====
// host processor model driving the display's strobe bus
// assumes one 200 MHz clock; pins move 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
module cdac_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic chip_select_low_n,
    output logic chip_select_high,
    output logic wr_n,
    output logic rd_n,
    output logic [1:0] addr_low,
    output logic register_space_select,
    output logic [7:0] data_in
);
    // idle bus at time zero; data is not left at a stale value
    initial begin
        chip_select_low_n = 1'h1;
        chip_select_high = 1'h0;
        wr_n = 1'h1;
        rd_n = 1'h1;
        addr_low = 2'h0;
        register_space_select = 1'h0;
        data_in = 8'hA5;
    end
    // ---------------------------------------------------------------
    // bus cycles
    // ---------------------------------------------------------------
    // select and address set up before the strobe, synchroniser lag
    task automatic setup(input logic [2:0] a, input logic sel);
        @(posedge ref_clk);
        #1;
        chip_select_low_n = 1'h0;
        chip_select_high = sel;
        register_space_select = a[2];
        addr_low = a[1:0];
    endtask
    // one write; select stays until the sync chain has seen the rise
    task automatic wr(input logic [2:0] a, input logic [7:0] d,
        input logic sel);
        setup(a, sel);
        data_in = d;
        repeat (3) @(posedge ref_clk);
        #1;
        wr_n = 1'h0;
        repeat (5) @(posedge ref_clk);
        #1;
        wr_n = 1'h1;
        repeat (3) @(posedge ref_clk);
        #1;
        chip_select_low_n = 1'h1;
        chip_select_high = 1'h0;
        data_in = ~d; // released: not the last value
        repeat (3) @(posedge ref_clk);
    endtask
    // one read; data taken while the strobe is still low
    task automatic rd(input logic [2:0] a, output logic [7:0] d,
        output logic oe);
        setup(a, 1'h1);
        repeat (3) @(posedge ref_clk);
        #1;
        rd_n = 1'h0;
        repeat (5) @(posedge ref_clk);
        d = data_out;
        oe = data_oe;
        #1;
        rd_n = 1'h1;
        chip_select_low_n = 1'h1;
        chip_select_high = 1'h0;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // cdac_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the display character and control store
// assumes the host model owns every bus pin of the design
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic cs_n, cs_h, wr_n, rd_n, rss, oe, rd_oe;
    logic [1:0] al, bright;
    logic [7:0] din, dout, cw, rv;
    logic [6:0] g0, g1, g2, g3;
    logic [3:0] dark, cur, half, dor, dand, cor, cand;
    int n_fail = 0;
    int n_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    cdac_host_model host (.ref_clk(ref_clk), .data_out(dout),
        .data_oe(oe), .chip_select_low_n(cs_n), .chip_select_high(cs_h),
        .wr_n(wr_n), .rd_n(rd_n), .addr_low(al),
        .register_space_select(rss), .data_in(din));
    // short blink half period keeps the run small
    cdac_display_ctrl #(.BLINK_HALF(8)) DUT (.ref_clk(ref_clk),
        .rstn(rstn), .chip_select_low_n(cs_n), .chip_select_high(cs_h),
        .wr_n(wr_n), .rd_n(rd_n), .addr_low(al),
        .register_space_select(rss), .data_in(din), .data_out(dout),
        .data_oe(oe), .glyph_code_0(g0), .glyph_code_1(g1),
        .glyph_code_2(g2), .glyph_code_3(g3), .digit_dark(dark),
        .digit_cursor(cur), .digit_half(half), .brightness(bright),
        .control_word(cw));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // collect highs and lows over five blink half periods
    task automatic span;
        dor = 4'h0;
        dand = 4'hF;
        cor = 4'h0;
        cand = 4'hF;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            dor = dor | dark;
            dand = dand & dark;
            cor = cor | cur;
            cand = cand & cur;
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: tests need roughly 600 cycles
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        rstn = 1'h1;
        chk("ctrl rst", 8'h00, cw);
        chk("dark rst", 8'h0F, {4'h0, dark});
        $display("test reset done");
        // brightness codes, each read back through a different low address
        for (int b = 0; b < 4; b++) begin
            host.wr(3'h0, 8'(b), 1'h1);
            chk("bright", 8'(b), {6'h0, bright});
            host.rd(3'(b), rv, rd_oe);
            chk("ctrl copy", 8'(b), rv);
        end
        // spell a word, right to left digit addresses 4..7
        host.wr(3'h7, 8'h53, 1'h1);
        host.wr(3'h6, 8'h54, 1'h1);
        host.wr(3'h5, 8'hCF, 1'h1);
        host.wr(3'h4, 8'h50, 1'h1);
        host.wr(3'h4, 8'h41, 1'h0); // deselected: ignored
        chk("g3", 8'h53, {1'h0, g3});
        chk("g1", 8'h4F, {1'h0, g1});
        chk("g2", 8'h54, {1'h0, g2});
        chk("g0", 8'h50, {1'h0, g0});
        host.rd(3'h5, rv, rd_oe);
        chk("rd d1", 8'hCF, rv);
        chk("oe", 8'h01, {7'h0, rd_oe});
        chk("oe off", 8'h00, {7'h0, oe});
        $display("test load done");
        host.wr(3'h0, 8'h17, 1'h1);
        span();
        chk("blink1 or", 8'h02, {4'h0, dor});
        chk("blink1 and", 8'h00, {4'h0, dand});
        host.wr(3'h7, 8'hD3, 1'h1);
        span();
        chk("blink2 or", 8'h0A, {4'h0, dor});
        chk("g3 kept", 8'h53, {1'h0, g3});
        host.wr(3'h0, 8'h1F, 1'h1);
        span();
        chk("alt or", 8'h0A, {4'h0, cor});
        chk("alt and", 8'h00, {4'h0, cand});
        host.wr(3'h0, 8'h23, 1'h1);
        span();
        chk("disp or", 8'h0F, {4'h0, dor});
        chk("disp and", 8'h00, {4'h0, dand});
        host.wr(3'h0, 8'h13, 1'h1);
        span();
        chk("cursor", 8'h0A, {4'h0, cand});
        host.wr(3'h0, 8'h40, 1'h1);
        chk("lamp", 8'h0F, {4'h0, half});
        $display("test attributes done");
        // first 32 codes dark, space onward lit
        host.wr(3'h0, 8'h03, 1'h1);
        host.wr(3'h4, 8'h00, 1'h1);
        chk("dark 00", 8'h01, {7'h0, dark[0]});
        host.wr(3'h4, 8'h1F, 1'h1);
        chk("dark 1F", 8'h01, {7'h0, dark[0]});
        host.wr(3'h4, 8'h20, 1'h1);
        chk("dark 20", 8'h00, {7'h0, dark[0]});
        host.wr(3'h0, 8'h80, 1'h1);
        chk("clr ctrl", 8'h00, cw);
        chk("clr g3", 8'h00, {1'h0, g3});
        host.rd(3'h6, rv, rd_oe);
        chk("clr d2", 8'h00, rv);
        $display("test dark and clear done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
